// File: sens_defs.svh
// Register map, reset values, field positions and frame counts of the sensor block.
`ifndef SENS_DEFS_SVH
`define SENS_DEFS_SVH
`define A_STATUS 3'h0
`define A_SETUP 3'h1
`define A_RESULT 3'h2
`define A_IDENT 3'h3
`define A_CRIT 3'h4
`define A_HYST 3'h5
`define A_UPPER 3'h6
`define A_LOWER 3'h7
`define RST_STATUS 8'h80
`define RST_SETUP 8'h00
`define RST_RESULT 16'h0000
`define RST_CRIT 16'h4980
`define RST_HYST 8'h05
`define RST_UPPER 16'h2000
`define RST_LOWER 16'h0500
`define ID_DEFAULT 8'h5A
`define B_RES 7
`define B_MODE_HI 6
`define B_MODE_LO 5
`define B_RDY 7
`define B_CRIT 6
`define B_HIGH 5
`define B_LOW 4
`define B_CMD_RD 6
`define B_CMD_A_HI 5
`define B_CMD_A_LO 3
`define FMT13_LSB 3
`define HYST_UNIT 7
`define CNT_CMD 5'h07
`define CNT_SHORT 5'h0F
`define CNT_LONG 5'h17
`define CNT_MAX 5'h1F
`endif

// File: sens_pkg.sv
// Types shared by the temperature register block.
package sens_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_DATA = 2'b11
  } spi_state_e;
  typedef enum logic [1:0] {
    MODE_CONT = 2'b00,
    MODE_ONESHOT = 2'b01,
    MODE_1SPS = 2'b10,
    MODE_SHUTDOWN = 2'b11
  } op_mode_e;
  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } conv_s;
endpackage

// File: spi_host_model.sv
// Serial register host that runs command and data frames against the sensor block.
`timescale 1ns/1ps
module spi_host_model (
  input wire logic sys_clk,
  input wire logic dout,
  input wire logic dout_en_n,
  output logic sclk,
  output logic cs_n,
  output logic din
);
  // Idle levels: clock high, device not selected.
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // Waits a number of falling system clock edges.
  task automatic gap(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One frame: command byte, then nd data bits, both MSB first.
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nd,
                      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd << (16 - nd)};
    rd = 16'h0000;
    gap(1);
    cs_n = 1'b0;
    gap(4);
    // Data changes in the low half and is read just before the rising edge.
    for (int i = 0; i < 8 + nd; i++) begin
      sclk = 1'b0;
      din = sh[23 - i];
      gap(4);
      // An undriven line reads as pulled high. Result arrives as two bytes.
      rd = {rd[14:0], dout_en_n ? 1'b1 : dout};
      sclk = 1'b1;
      gap(4);
    end
    cs_n = 1'b1;
    din = ~din; // A released line shows no stale value.
    gap(6);
  endtask
endmodule // spi_host_model

// File: temp_regs.sv
// Temperature result, limit and status registers behind a serial register port.
`timescale 1ns/1ps
`include "sens_defs.svh"

// Notes on behaviour
// R1: 13-bit step is 0.0625 degree.
// R2: Store result, compare with three limits.
// R3: Result and limits are twos-complement words.
// R4: 13-bit mode: bits 2..0 hold flags.
// R5: Bit2 critical, bit1 high, bit0 low.
// R6: Resolution bit set gives full 16 bits.
// R7: Power-on format is 13-bit.
// R8: Result delivered as two serial bytes.
// R9: 13-bit code sits in bits 15..3.
// R10: 13-bit code is temperature times 16.
// R11: 16-bit code is temperature times 128.
// R12: Host may drop bits 6..3.
// R13: Eight registers at addresses 0 to 7.
// R14: Status, result, identity ignore writes.
// R15: Flags clear on status read or hysteresis.
// R16: Low flag sets below, clears above margin.
// R17: High flag sets above, clears below margin.
// R18: Critical flag sets above, clears below margin.
// R19: Ready low on result, high on read.
// R20: One-shot bits write restores ready.
// R21: Setup bits 6..5 select operating mode.
module temp_regs
  import sens_pkg::*;
#(
  parameter logic [7:0] ID_CODE = `ID_DEFAULT, // Arbitrary identity value.
  parameter int CODE_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire conv_s conv,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_ff,
  output logic dout_en_n_ff,
  output op_mode_e op_mode_ff
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  // The register layout only serves a 16-bit code.
  if (CODE_W != 16) begin : g_bad_width
    $error("CODE_W must be 16");
  end

  // ************************************************************
  // Reset and input synchronisers
  // ************************************************************
  logic rst_s1_ff;
  logic rst_n_ff;
  logic sclk_s1_ff, sclk_s2_ff, sclk_d_ff;
  logic cs_s1_ff, cs_s2_ff;
  logic din_s1_ff, din_s2_ff;

  // Reset is released through two flops; pins pass two flops before use.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
      sclk_s1_ff <= 1'b1;
      sclk_s2_ff <= 1'b1;
      sclk_d_ff <= 1'b1;
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
      sclk_s1_ff <= sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_d_ff <= sclk_s2_ff;
      cs_s1_ff <= cs_n;
      cs_s2_ff <= cs_s1_ff;
      din_s1_ff <= din;
      din_s2_ff <= din_s1_ff;
    end
  end

  // ************************************************************
  // Registers and frame state
  // ************************************************************
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] setup_ff, nxt_setup;
  logic [15:0] res_ff, nxt_res;
  logic [15:0] crit_ff, nxt_crit;
  logic [7:0] hyst_ff, nxt_hyst;
  logic [15:0] upper_ff, nxt_upper;
  logic [15:0] lower_ff, nxt_lower;
  spi_state_e state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] rx_ff, nxt_rx;
  logic [15:0] tx_ff, nxt_tx;
  logic [2:0] addr_ff, nxt_addr;
  logic rd_ff, nxt_rd;
  logic nxt_dout, nxt_dout_en_n;

  // ************************************************************
  // Limit comparison
  // ************************************************************
  logic sclk_rise, sclk_fall;
  logic [15:0] meas;
  logic signed [16:0] t_s, crit_s, upper_s, lower_s, hyst_s;
  logic over_crit, over_high, under_low;
  logic crit_back, high_back, low_back;

  assign sclk_rise = sclk_s2_ff & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s2_ff & sclk_d_ff;

  // In 13-bit mode the three low bits are not temperature, so both sides
  // of every comparison drop them; the MSB is the sign. [R1] [R3] [R7]
  always_comb begin
    meas = conv.code;
    if (!setup_ff[`B_RES]) begin
      meas[`FMT13_LSB-1:0] = '0;
    end
    t_s = {meas[15], meas};
    crit_s = {crit_ff[15], crit_ff[15:`FMT13_LSB], 3'h0};
    upper_s = {upper_ff[15], upper_ff[15:`FMT13_LSB], 3'h0};
    lower_s = {lower_ff[15], lower_ff[15:`FMT13_LSB], 3'h0};
    if (setup_ff[`B_RES]) begin
      crit_s = {crit_ff[15], crit_ff};
      upper_s = {upper_ff[15], upper_ff};
      lower_s = {lower_ff[15], lower_ff};
    end
    // Margin is whole degrees, 128 steps of the 16-bit code each. [R11]
    hyst_s = 17'(hyst_ff[3:0]) <<< `HYST_UNIT;
  end

  // Set and return conditions against the three limits. [R2]
  assign over_crit = t_s > crit_s;
  assign over_high = t_s > upper_s;
  assign under_low = t_s < lower_s;
  assign crit_back = t_s < (crit_s - hyst_s);
  assign high_back = t_s < (upper_s - hyst_s);
  assign low_back = t_s > (lower_s + hyst_s);

  // ************************************************************
  // Next-state logic
  // ************************************************************
  logic [7:0] cmd;
  logic [15:0] wdata;
  logic [15:0] rval;
  logic rd_fire, wr_fire, stat_rd, res_rd, wide;

  // Frame decode, register update and flag handling.
  always_comb begin
    nxt_stat = stat_ff;
    nxt_setup = setup_ff;
    nxt_res = res_ff;
    nxt_crit = crit_ff;
    nxt_hyst = hyst_ff;
    nxt_upper = upper_ff;
    nxt_lower = lower_ff;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_addr = addr_ff;
    nxt_rd = rd_ff;
    nxt_dout = dout_ff;
    nxt_dout_en_n = dout_en_n_ff;
    cmd = {rx_ff[6:0], din_s2_ff};
    wdata = {rx_ff[14:0], din_s2_ff};
    rd_fire = 1'b0;
    wr_fire = 1'b0;
    // Result, limits other than margin are 16 bits wide. [R13]
    wide = (addr_ff == `A_RESULT) || (addr_ff == `A_CRIT) ||
           (addr_ff == `A_UPPER) || (addr_ff == `A_LOWER);
    // Register read mux; 8-bit registers go out first in the top byte.
    unique case (cmd[`B_CMD_A_HI:`B_CMD_A_LO])
      `A_STATUS: rval = {stat_ff, 8'h00};
      `A_SETUP: rval = {setup_ff, 8'h00};
      `A_RESULT: rval = res_ff; // [R8]
      `A_IDENT: rval = {ID_CODE, 8'h00};
      `A_CRIT: rval = crit_ff;
      `A_HYST: rval = {hyst_ff, 8'h00};
      `A_UPPER: rval = upper_ff;
      `A_LOWER: rval = lower_ff;
    endcase
    if (cs_s2_ff) begin
      nxt_state = ST_IDLE;
      nxt_dout_en_n = 1'b1;
      nxt_dout = 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_CMD;
          nxt_cnt = '0;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            nxt_rx = wdata;
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == `CNT_CMD) begin
              nxt_state = ST_DATA;
              nxt_addr = cmd[`B_CMD_A_HI:`B_CMD_A_LO];
              nxt_rd = cmd[`B_CMD_RD];
              rd_fire = cmd[`B_CMD_RD];
              nxt_tx = rval;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            nxt_rx = wdata;
            if (cnt_ff != `CNT_MAX) begin
              nxt_cnt = cnt_ff + 5'h01;
            end
            wr_fire = !rd_ff && (cnt_ff == (wide ? `CNT_LONG : `CNT_SHORT));
          end
          // Read data changes on the falling edge, MSB first. [R8]
          if (sclk_fall && rd_ff) begin
            nxt_dout = tx_ff[15];
            nxt_tx = {tx_ff[14:0], 1'b0};
            nxt_dout_en_n = 1'b0;
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
    stat_rd = rd_fire && (cmd[`B_CMD_A_HI:`B_CMD_A_LO] == `A_STATUS);
    res_rd = rd_fire && (cmd[`B_CMD_A_HI:`B_CMD_A_LO] == `A_RESULT);
    // Writes reach only setup and limit registers. [R14]
    if (wr_fire) begin
      unique case (addr_ff)
        `A_SETUP: begin
          nxt_setup = wdata[7:0];
          // A write of one-shot or 1 SPS bits restores ready. [R20]
          if ((wdata[`B_MODE_HI:`B_MODE_LO] == MODE_ONESHOT) ||
              (wdata[`B_MODE_HI:`B_MODE_LO] == MODE_1SPS)) begin
            nxt_stat[`B_RDY] = 1'b1;
          end
        end
        `A_CRIT: nxt_crit = wdata;
        `A_HYST: nxt_hyst = wdata[7:0];
        `A_UPPER: nxt_upper = wdata;
        `A_LOWER: nxt_lower = wdata;
        default: ;
      endcase
    end
    // Reading status clears the three flags. [R15]
    if (stat_rd) begin
      nxt_stat[`B_CRIT:`B_LOW] = 3'h0;
    end
    // Reading the result restores ready. [R19]
    if (res_rd) begin
      nxt_stat[`B_RDY] = 1'b1;
    end
    // A new result is stored and beats any clear in the same cycle.
    if (conv.valid) begin
      nxt_res = conv.code; // [R6] [R11]
      if (!setup_ff[`B_RES]) begin
        nxt_res = {conv.code[15:`FMT13_LSB], over_crit, over_high, under_low}; // [R4] [R5] [R9] [R10]
      end
      nxt_stat[`B_RDY] = 1'b0; // [R19]
      if (crit_back) nxt_stat[`B_CRIT] = 1'b0; // [R18]
      if (high_back) nxt_stat[`B_HIGH] = 1'b0; // [R17]
      if (low_back) nxt_stat[`B_LOW] = 1'b0; // [R16]
      if (over_crit) nxt_stat[`B_CRIT] = 1'b1; // [R18]
      if (over_high) nxt_stat[`B_HIGH] = 1'b1; // [R17]
      if (under_low) nxt_stat[`B_LOW] = 1'b1; // [R16]
    end
  end

  // ************************************************************
  // State registers
  // ************************************************************
  // Registers only; all values come from the block above.
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      stat_ff <= `RST_STATUS;
      setup_ff <= `RST_SETUP; // [R7]
      res_ff <= `RST_RESULT;
      crit_ff <= `RST_CRIT;
      hyst_ff <= `RST_HYST;
      upper_ff <= `RST_UPPER;
      lower_ff <= `RST_LOWER;
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      rx_ff <= '0;
      tx_ff <= '0;
      addr_ff <= `A_STATUS;
      rd_ff <= 1'b0;
      dout_ff <= 1'b0;
      dout_en_n_ff <= 1'b1;
      op_mode_ff <= MODE_CONT;
    end else begin
      stat_ff <= nxt_stat;
      setup_ff <= nxt_setup;
      res_ff <= nxt_res;
      crit_ff <= nxt_crit;
      hyst_ff <= nxt_hyst;
      upper_ff <= nxt_upper;
      lower_ff <= nxt_lower;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      addr_ff <= nxt_addr;
      rd_ff <= nxt_rd;
      dout_ff <= nxt_dout;
      dout_en_n_ff <= nxt_dout_en_n;
      op_mode_ff <= op_mode_e'(nxt_setup[`B_MODE_HI:`B_MODE_LO]); // [R21]
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_ff);

  // Checks of result formatting, flags and register access.
  a_rdy_on_result: assert property (conv.valid |=> !stat_ff[`B_RDY]) // [R19]
    else $error("ready not low after new result");
  a_rdy_on_read: assert property (res_rd && !conv.valid |=> stat_ff[`B_RDY]) // [R19]
    else $error("ready not restored by result read");
  a_crit_set: assert property (conv.valid && over_crit |=> stat_ff[`B_CRIT]) // [R18]
    else $error("critical flag not set");
  a_high_set: assert property (conv.valid && over_high |=> stat_ff[`B_HIGH]) // [R17]
    else $error("high flag not set");
  a_low_set: assert property (conv.valid && under_low |=> stat_ff[`B_LOW]) // [R16]
    else $error("low flag not set");
  a_flag_clear: assert property (stat_rd && !conv.valid |=> stat_ff[6:4] == 3'h0) // [R15]
    else $error("flags not cleared by status read");
  a_fmt_short: assert property (conv.valid && !setup_ff[`B_RES] |=> // [R4]
    res_ff == {$past(conv.code[15:`FMT13_LSB]), $past(over_crit), $past(over_high),
               $past(under_low)})
    else $error("13-bit result layout wrong");
  a_fmt_full: assert property (conv.valid && setup_ff[`B_RES] |=> // [R6]
    res_ff == $past(conv.code))
    else $error("16-bit result wrong");
  a_ro_result: assert property (wr_fire && addr_ff == `A_RESULT && !conv.valid |=> // [R14]
    $stable(res_ff))
    else $error("result register took a write");
  a_dout_idle: assert property (cs_s2_ff |=> dout_en_n_ff) // [R8]
    else $error("output driven while deselected");

  c_status_read: cover property (stat_rd && stat_ff[`B_CRIT]);
  c_result_read: cover property (res_rd && !stat_ff[`B_RDY]);
  c_setup_write: cover property (wr_fire && addr_ff == `A_SETUP);
  c_full_res: cover property (conv.valid && setup_ff[`B_RES]);

endmodule // temp_regs

// File: temp_result_limit_status_regs_tb_top.sv
// Self-checking bench for the temperature result, limit and status registers.
`timescale 1ns/1ps
`include "sens_defs.svh"
module temp_result_limit_status_regs_tb_top;
  import sens_pkg::*;
  logic sys_clk, nrst, sclk, cs_n, din, dout_ff, dout_en_n_ff;
  conv_s conv;
  op_mode_e op_mode_ff;
  int fails, n_tests;
  logic [15:0] rst_tab [8] = '{16'h0080, 16'h0000, 16'h0000, {8'h00, `ID_DEFAULT},
                               16'h4980, 16'h0005, 16'h2000, 16'h0500};

  temp_regs dut_u (.sys_clk(sys_clk), .nrst(nrst), .conv(conv), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout_ff(dout_ff), .dout_en_n_ff(dout_en_n_ff),
    .op_mode_ff(op_mode_ff));
  spi_host_model host_u (.sys_clk(sys_clk), .dout(dout_ff), .dout_en_n(dout_en_n_ff),
    .sclk(sclk), .cs_n(cs_n), .din(din));

  // The system clock runs at 10 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ************************************
  // Access and compare tasks
  // ************************************
  function automatic int nbits(input logic [2:0] a);
    return (a inside {`A_STATUS, `A_SETUP, `A_IDENT, `A_HYST}) ? 8 : 16;
  endfunction
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] v);
    logic [15:0] d;
    host_u.xfer({2'b00, a, 3'h0}, v, nbits(a), d);
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host_u.xfer({2'b01, a, 3'h0}, 16'h0000, nbits(a), v);
    if (nbits(a) == 8) begin
      v = {8'h00, v[7:0]};
    end
    chk_val(v, exp);
  endtask
  task automatic chk_mode(input op_mode_e got, input op_mode_e exp);
    chk_val({14'h0000, got}, {14'h0000, exp});
  endtask
  // A one-cycle conversion pulse carrying a 1/128 degree code.
  task automatic convert(input logic [15:0] c);
    @(negedge sys_clk);
    conv = '{valid: 1'b1, code: c};
    @(negedge sys_clk);
    conv.valid = 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    $display("watchdog expired");
    wrap_up();
  end

  // ************************************
  // Test sequence
  // ************************************
  initial begin
    logic [15:0] rv;
    nrst = 1'b0;
    conv = '0;
    fails = 0;
    n_tests = 0;
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (5) @(negedge sys_clk);
    // Power-on contents of all eight registers.
    foreach (rst_tab[i]) chk_rd(3'(i), rst_tab[i]);
    $display("test reset_values done");
    // Read-only places ignore writes, a limit takes a new value.
    wr_reg(`A_STATUS, 16'h0011);
    wr_reg(`A_RESULT, 16'h1234);
    wr_reg(`A_IDENT, 16'h00FF);
    wr_reg(`A_CRIT, 16'h5A18);
    chk_rd(`A_STATUS, 16'h0080);
    chk_rd(`A_RESULT, 16'h0000);
    chk_rd(`A_IDENT, {8'h00, `ID_DEFAULT});
    chk_rd(`A_CRIT, 16'h5A18);
    wr_reg(`A_CRIT, 16'h4980);
    $display("test write_access done");
    // 25.0625 degrees with sub-step bits: 13-bit result drops bits 2..0.
    convert(16'h0C8F);
    chk_rd(`A_STATUS, 16'h0000);
    chk_rd(`A_RESULT, 16'h0C88);
    // A 9-bit host keeps bits 15..7 only and sees whole degrees.
    host_u.xfer({2'b01, `A_RESULT, 3'h0}, 16'h0000, 16, rv);
    chk_val({7'h00, rv[15:7]}, 16'h0019);
    chk_rd(`A_STATUS, 16'h0080);
    // Minus 55 degrees is below the lower limit.
    convert(16'hE480);
    chk_rd(`A_RESULT, 16'hE481);
    chk_rd(`A_STATUS, 16'h0090);
    chk_rd(`A_STATUS, 16'h0080);
    // Low flag holds at exactly limit plus margin, clears one degree above.
    convert(16'hE480);
    convert(16'h0780);
    chk_rd(`A_STATUS, 16'h0010);
    convert(16'hE480);
    convert(16'h0800);
    chk_rd(`A_STATUS, 16'h0000);
    $display("test low_limit done");
    // 150 degrees passes both upper limits, then 141 clears only critical.
    convert(16'h4B00);
    chk_rd(`A_RESULT, 16'h4B06);
    convert(16'h4680);
    chk_rd(`A_STATUS, 16'h0020);
    chk_rd(`A_STATUS, 16'h0000);
    chk_rd(`A_RESULT, 16'h4682);
    chk_rd(`A_STATUS, 16'h0080);
    $display("test upper_limits done");
    // Full 16-bit resolution keeps the low magnitude bits.
    wr_reg(`A_SETUP, 16'h0080);
    chk_rd(`A_SETUP, 16'h0080);
    convert(16'h0C81);
    chk_rd(`A_RESULT, 16'h0C81);
    convert(16'hFFFF);
    chk_rd(`A_RESULT, 16'hFFFF);
    wr_reg(`A_SETUP, 16'h0000);
    $display("test wide_format done");
    // Every operating mode, then a 1 SPS bits write restores ready.
    for (int m = 0; m < 4; m++) begin
      wr_reg(`A_SETUP, {9'h000, 2'(m), 5'h00});
      chk_mode(op_mode_ff, op_mode_e'(2'(m)));
    end
    convert(16'h0C80);
    wr_reg(`A_SETUP, 16'h0040);
    chk_rd(`A_STATUS, 16'h0080);
    wr_reg(`A_SETUP, 16'h0000);
    chk_mode(op_mode_ff, MODE_CONT);
    $display("test modes done");
    wrap_up();
  end
endmodule // temp_result_limit_status_regs_tb_top
